/* hdl/gpi_monitor_burst_timer_ctl.sv */
// Input monitor conditioning, thermal throttle and fast burst timer control with AXI4-Lite.
// Functional notes
// - Thermal duty code sets stop-clock fraction while alarm throttles; code 100 is 50%.
// - On stop-clock exit, load fast burst timer with PLL lock count, lock source.
// - Lock resolution bit selects 1 ms tick (0) or 8 us tick (1).
// - Fast burst count is the initial and reload value in normal timing.
// - Bit 27 makes monitor 13 input edge-sensitive, else level.
// - Bit 26 makes monitor 12 input edge-sensitive, else level.
// - Bits 25..13 select active-low per monitor input, bit 13 is monitor 1.
// - Bits 12..0 gate each monitor input into decode, bit 0 is monitor 1.
// - Monitor 0 has no input; monitors 1..7 use inputs 5,6,0,13,14,15,16.
// - Monitors 8..13 use inputs 17,4,18,19,20,21.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module gpi_monitor_burst_timer_ctl #(
  parameter int unsigned ADDR_W            = 8,
  parameter int unsigned LOCK_COARSE_CYC   = gpi_monitor_pkg::LOCK_TICK_COARSE_CYC,
  parameter int unsigned THROTTLE_SLOT_CYC = gpi_monitor_pkg::THROTTLE_SLOT_CYC
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic [21:0]       gen_in_i,
  input  wire logic              thermal_alarm_n_i,
  input  wire logic              cpu_stop_exit_i,
  input  wire logic              fb_reload_i,
  input  wire logic              fb_expired_i,
  output logic [13:0]            activity_o,
  output logic                   stop_clock_request_n_o,
  output logic                   fb_load_o,
  output logic [4:0]             fb_load_value_o,
  output logic                   fb_lock_mode_o,
  output logic                   fb_tick_o,
  output logic                   irq_o
);
  localparam int unsigned FINE_CYC = gpi_monitor_pkg::LOCK_TICK_FINE_CYC;
  localparam int unsigned TICK_W = $clog2(LOCK_COARSE_CYC + 1);
  localparam int unsigned SLOT_W = $clog2(THROTTLE_SLOT_CYC + 1);

  if (ADDR_W < 8 || LOCK_COARSE_CYC < FINE_CYC || THROTTLE_SLOT_CYC < 1) begin : g_bad_param
    $error("Unsupported parameter value.");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r & m;
  endfunction

  logic              aw_held_ff;
  logic [7:0]        awaddr_ff;
  logic              w_held_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;
  logic [31:0]       gimc_ff;
  logic [31:0]       tbc_ff;
  logic [31:0]       stat_ff;
  logic [31:0]       mask_ff;
  logic [13:1]       sync1_ff;
  logic [13:1]       sync2_ff;
  logic [13:1]       prev_ff;
  logic [13:1]       act_ff;
  logic [13:1]       nxt_act;
  logic [1:0]        alarm_sync_ff;
  logic              alarm_prev_ff;
  logic [SLOT_W-1:0] slot_cnt_ff;
  logic [2:0]        phase_ff;
  logic              stop_n_ff;
  logic              fb_load_ff;
  logic [4:0]        fb_value_ff;
  logic              lock_mode_ff;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic              tick_ff;
  logic              wr_fire;
  logic              rd_fire;
  logic              wr_hit;
  logic [7:0]        rd_addr;
  logic [31:0]       nxt_rdata;
  logic              rd_hit;
  logic [31:0]       w1c;
  logic [31:0]       events;
  logic [2:0]        duty;
  logic              throttling;
  logic [TICK_W-1:0] tick_last;

  assign s_axi_awready_o = !aw_held_ff;
  assign s_axi_wready_o  = !w_held_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_arready_o = !rvalid_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rresp_o   = rresp_ff;
  assign s_axi_rdata_o   = rdata_ff;

  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign rd_fire = s_axi_arvalid_i && !rvalid_ff;
  assign rd_addr = {s_axi_araddr_i[7:2], 2'h0};
  assign wr_hit  = awaddr_ff == gpi_monitor_pkg::OFFS_TBC ||
                   awaddr_ff == gpi_monitor_pkg::OFFS_GIMC ||
                   awaddr_ff == gpi_monitor_pkg::OFFS_IRQ_STAT ||
                   awaddr_ff == gpi_monitor_pkg::OFFS_IRQ_MASK;

  // Address and data are caught independently, so either may arrive first.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
      w_held_ff  <= 1'b0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr_i[7:2], 2'h0};
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid_i && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata_i;
        wstrb_ff  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= gpi_monitor_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? gpi_monitor_pkg::RESP_OKAY : gpi_monitor_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_comb begin
    rd_hit    = 1'b1;
    nxt_rdata = 32'h0000_0000;
    unique case (rd_addr)
      gpi_monitor_pkg::OFFS_TBC:      nxt_rdata = tbc_ff;
      gpi_monitor_pkg::OFFS_GIMC:     nxt_rdata = gimc_ff;
      gpi_monitor_pkg::OFFS_IRQ_STAT: nxt_rdata = stat_ff;
      gpi_monitor_pkg::OFFS_IRQ_MASK: nxt_rdata = mask_ff;
      gpi_monitor_pkg::OFFS_IN_STATE: begin
        nxt_rdata = {16'h0000, stop_n_ff, lock_mode_ff, alarm_sync_ff[1], sync2_ff};
      end
      default:                        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= gpi_monitor_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_hit ? gpi_monitor_pkg::RESP_OKAY : gpi_monitor_pkg::RESP_SLVERR;
      rdata_ff  <= nxt_rdata;
    end else if (s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gimc_ff <= gpi_monitor_pkg::GIMC_RESET;
      tbc_ff  <= gpi_monitor_pkg::TBC_RESET;
      mask_ff <= gpi_monitor_pkg::IRQ_RESET;
    end else if (wr_fire) begin
      if (awaddr_ff == gpi_monitor_pkg::OFFS_GIMC) begin
        gimc_ff <= merge(gimc_ff, wdata_ff, wstrb_ff, gpi_monitor_pkg::GIMC_WMASK);
      end
      if (awaddr_ff == gpi_monitor_pkg::OFFS_TBC) begin
        tbc_ff <= merge(tbc_ff, wdata_ff, wstrb_ff, gpi_monitor_pkg::TBC_WMASK);
      end
      if (awaddr_ff == gpi_monitor_pkg::OFFS_IRQ_MASK) begin
        mask_ff <= merge(mask_ff, wdata_ff, wstrb_ff, gpi_monitor_pkg::IRQ_WMASK);
      end
    end
  end

  // Monitor 1 sits in bit 0 of each per-monitor field.
  for (genvar m = 1; m <= 13; m++) begin : g_mon
    logic asserted;
    logic edge_mode;
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        sync1_ff[m] <= 1'b0;
        sync2_ff[m] <= 1'b0;
      end else begin
        sync1_ff[m] <= gen_in_i[gpi_monitor_pkg::MON_SRC[m]];
        sync2_ff[m] <= sync1_ff[m];
      end
    end
    assign asserted = sync2_ff[m] ^ gimc_ff[gpi_monitor_pkg::GIMC_POL_LSB + m - 1];
    if (m == 13) begin : g_e13
      assign edge_mode = gimc_ff[gpi_monitor_pkg::GIMC_EDGE13_BIT];
    end else if (m == 12) begin : g_e12
      assign edge_mode = gimc_ff[gpi_monitor_pkg::GIMC_EDGE12_BIT];
    end else begin : g_lvl
      assign edge_mode = 1'b0;
    end
    always_ff @(posedge clock_i) begin
      if (rst_i) begin
        prev_ff[m] <= 1'b0;
      end else begin
        prev_ff[m] <= asserted;
      end
    end
    // Edge mode yields one pulse per entry into the active level.
    assign nxt_act[m] = gimc_ff[gpi_monitor_pkg::GIMC_EN_LSB + m - 1] &&
                        (edge_mode ? (asserted && !prev_ff[m]) : asserted);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      act_ff <= 13'h0000;
    end else begin
      act_ff <= nxt_act;
    end
  end

  assign activity_o = {act_ff, 1'b0};

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      alarm_sync_ff <= 2'h3;
      alarm_prev_ff <= 1'b1;
    end else begin
      alarm_sync_ff <= {alarm_sync_ff[0], thermal_alarm_n_i};
      alarm_prev_ff <= alarm_sync_ff[1];
    end
  end

  // A new event wins over a write-one-to-clear in the same cycle.
  always_comb begin
    events = 32'h0000_0000;
    events[12:0] = nxt_act & ~act_ff;
    events[gpi_monitor_pkg::IRQ_THERM_BIT] = alarm_prev_ff && !alarm_sync_ff[1];
    w1c = 32'h0000_0000;
    if (wr_fire && awaddr_ff == gpi_monitor_pkg::OFFS_IRQ_STAT) begin
      w1c = merge(32'h0000_0000, wdata_ff, wstrb_ff, gpi_monitor_pkg::IRQ_WMASK);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stat_ff <= gpi_monitor_pkg::IRQ_RESET;
    end else begin
      stat_ff <= (stat_ff & ~w1c) | events;
    end
  end

  assign irq_o = |(stat_ff & mask_ff);

  // Eight slots per throttle period; the duty code counts asserted slots.
  assign duty       = tbc_ff[gpi_monitor_pkg::TBC_DUTY_LSB +: 3];
  assign throttling = !alarm_sync_ff[1];

  always_ff @(posedge clock_i) begin
    if (rst_i || !throttling) begin
      slot_cnt_ff <= '0;
      phase_ff    <= 3'h0;
    end else if (slot_cnt_ff == SLOT_W'(THROTTLE_SLOT_CYC - 1)) begin
      slot_cnt_ff <= '0;
      phase_ff    <= phase_ff + 3'h1;
    end else begin
      slot_cnt_ff <= slot_cnt_ff + SLOT_W'(1);
    end
  end

  // The reserved code 000 never asserts the request rather than stopping the clock outright.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stop_n_ff <= 1'b1;
    end else begin
      stop_n_ff <= !(throttling && phase_ff < duty);
    end
  end

  assign stop_clock_request_n_o = stop_n_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      fb_load_ff   <= 1'b0;
      fb_value_ff  <= 5'h00;
      lock_mode_ff <= 1'b0;
    end else begin
      fb_load_ff <= cpu_stop_exit_i || fb_reload_i;
      if (cpu_stop_exit_i) begin
        fb_value_ff  <= tbc_ff[gpi_monitor_pkg::TBC_LOCK_LSB +: 5];
        lock_mode_ff <= 1'b1;
      end else if (fb_reload_i) begin
        fb_value_ff  <= tbc_ff[gpi_monitor_pkg::TBC_FBCNT_LSB +: 5];
        lock_mode_ff <= 1'b0;
      end else if (fb_expired_i) begin
        lock_mode_ff <= 1'b0;
      end
    end
  end

  assign fb_load_o       = fb_load_ff;
  assign fb_load_value_o = fb_value_ff;
  assign fb_lock_mode_o  = lock_mode_ff;

  assign tick_last = tbc_ff[gpi_monitor_pkg::TBC_RES_BIT] ?
                     TICK_W'(FINE_CYC - 1) : TICK_W'(LOCK_COARSE_CYC - 1);

  // The tick restarts on every lock load so the first period is whole.
  always_ff @(posedge clock_i) begin
    if (rst_i || cpu_stop_exit_i || !lock_mode_ff) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff >= tick_last) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
      tick_ff     <= 1'b0;
    end
  end

  assign fb_tick_o = tick_ff;
endmodule

/* shared/gpi_monitor_pkg.sv */
// Package of register map, field layout and timing constants for the input monitor block.
package gpi_monitor_pkg;
  localparam int unsigned NUM_MON = 13;
  localparam int unsigned NUM_GEN_IN = 22;
  localparam int unsigned MON_SRC [1:13] = '{5, 6, 0, 13, 14, 15, 16, 17, 4, 18, 19, 20, 21};

  localparam logic [7:0] OFFS_TBC = 8'h48;
  localparam logic [7:0] OFFS_GIMC = 8'h4C;
  localparam logic [7:0] OFFS_IRQ_STAT = 8'h60;
  localparam logic [7:0] OFFS_IRQ_MASK = 8'h64;
  localparam logic [7:0] OFFS_IN_STATE = 8'h68;

  localparam int unsigned GIMC_EDGE13_BIT = 27;
  localparam int unsigned GIMC_EDGE12_BIT = 26;
  localparam int unsigned GIMC_POL_LSB = 13;
  localparam int unsigned GIMC_EN_LSB = 0;
  localparam logic [31:0] GIMC_RESET = 32'h0000_0000;
  localparam logic [31:0] GIMC_WMASK = 32'h0FFF_FFFF;

  localparam int unsigned TBC_DUTY_LSB = 11;
  localparam int unsigned TBC_LOCK_LSB = 6;
  localparam int unsigned TBC_RES_BIT = 5;
  localparam int unsigned TBC_FBCNT_LSB = 0;
  localparam logic [31:0] TBC_RESET = 32'h0000_0000;
  localparam logic [31:0] TBC_WMASK = 32'h0000_3FFF;

  localparam int unsigned IRQ_THERM_BIT = 13;
  localparam logic [31:0] IRQ_WMASK = 32'h0000_3FFF;
  localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LOCK_TICK_FINE_NS = 8000;
  localparam int unsigned LOCK_TICK_COARSE_NS = 1000000;
  localparam int unsigned LOCK_TICK_FINE_CYC = LOCK_TICK_FINE_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_TICK_COARSE_CYC = LOCK_TICK_COARSE_NS / CLK_PERIOD_NS;
  localparam int unsigned THROTTLE_SLOT_CYC = 256;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* testbench/gpi_monitor_burst_timer_ctl_monitor.sv */
// Port-level checker for the input monitor and fast burst timer block.
`timescale 1ns/1ps
module gpi_monitor_burst_timer_ctl_monitor (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        s_axi_bvalid_o,
  input wire logic [21:0] gen_in_i,
  input wire logic        thermal_alarm_n_i,
  input wire logic        cpu_stop_exit_i,
  input wire logic        fb_reload_i,
  input wire logic        fb_expired_i,
  input wire logic [13:0] activity_o,
  input wire logic        stop_clock_request_n_o,
  input wire logic        fb_load_o,
  input wire logic        fb_lock_mode_o,
  input wire logic        fb_tick_o
);
  localparam int SRC [1:11] = '{5, 6, 0, 13, 14, 15, 16, 17, 4, 18, 19};
  logic        bv_ff;
  logic        wr_done;
  logic [19:0] gap_ff;
  assign wr_done = s_axi_bvalid_o & ~bv_ff;
  default clocking dcb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clock_i) bv_ff <= s_axi_bvalid_o;
  // Held at zero outside lock mode, so only time spent counting lock ticks is measured.
  always_ff @(posedge clock_i) begin
    if (rst_i || fb_tick_o || !fb_lock_mode_o) begin
      gap_ff <= 20'h0;
    end else begin
      gap_ff <= gap_ff + 20'h1;
    end
  end
  AST_NO_MON0: assert property (!activity_o[0]) else $error("monitor 0 active");
  for (genvar m = 1; m <= 11; m++) begin : g_lvl
    // The cycle after reset sees activity leave its unknown start value, so it is skipped.
    AST_LEVEL_CAUSE: assert property (!$past(rst_i) &&
      $changed(activity_o[m]) |->
      $past(gen_in_i[SRC[m]], 3) != $past(gen_in_i[SRC[m]], 4) || $past(wr_done) ||
      $past(wr_done, 2)) else $error("activity moved without its pin");
  end
  AST_EXIT_LOAD: assert property (cpu_stop_exit_i |=> fb_load_o && fb_lock_mode_o)
    else $error("no lock load after stop exit");
  AST_RELOAD_LOAD: assert property (fb_reload_i && !cpu_stop_exit_i |=>
    fb_load_o && !fb_lock_mode_o) else $error("no burst reload");
  AST_LOAD_CAUSE: assert property (fb_load_o |->
    $past(cpu_stop_exit_i || fb_reload_i)) else $error("load without request");
  AST_EXPIRE: assert property (fb_expired_i && !cpu_stop_exit_i |=> !fb_lock_mode_o)
    else $error("lock mode kept after expiry");
  AST_TICK_GAP: assert property (fb_tick_o |-> gap_ff >= 20'h31F)
    else $error("lock tick too early");
  AST_STOP_IDLE: assert property (thermal_alarm_n_i [*5] |-> stop_clock_request_n_o)
    else $error("stop request without alarm");
  cover property (fb_tick_o);
  cover property ($rose(activity_o[12]));
  cover property ($fell(stop_clock_request_n_o));
endmodule

/* testbench/gen_in_board.sv */
// Board-side model of the general inputs and the thermal alarm pin.
`timescale 1ns/1ps
module gen_in_board (
  input  wire logic        clock_i,
  input  wire logic [21:0] pins_i,
  input  wire logic        alarm_n_i,
  output logic      [21:0] gen_in_o,
  output logic             thermal_alarm_n_o
);
  // Pins move 3 ns after a rising edge, so the block never samples them on the edge where they change.
  initial begin
    gen_in_o = 22'h0;
    thermal_alarm_n_o = 1'b1;
  end
  always @(posedge clock_i) begin
    gen_in_o <= #3 pins_i;
    thermal_alarm_n_o <= #3 alarm_n_i;
  end
endmodule

/* testbench/gpi_monitor_burst_timer_ctl_tb.sv */
// Self-checking bench for the input monitor and burst timer control block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module gpi_monitor_burst_timer_ctl_tb;
  logic        clock_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_rready_i, cpu_stop_exit_i, fb_reload_i, fb_expired_i;
  logic        alarm_n, thermal_alarm_n_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o, fb_load_o, fb_lock_mode_o, fb_tick_o, irq_o;
  logic        stop_clock_request_n_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [3:0]  s_axi_wstrb_i;
  logic [4:0]  fb_load_value_o, lk, fc;
  logic [5:0]  lexp, exp_ld[$];
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [13:0] activity_o;
  logic [21:0] pins, gen_in_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, g;
  logic [33:0] rexp, exp_rd[$];
  int          n_fail, n_checks, seed, i, m, k, n, c12, c13;
  int          src [1:13] = '{5, 6, 0, 13, 14, 15, 16, 17, 4, 18, 19, 20, 21};
  gpi_monitor_burst_timer_ctl #(.LOCK_COARSE_CYC(1000), .THROTTLE_SLOT_CYC(4))
    gpi_monitor_burst_timer_ctl_inst (.clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .gen_in_i, .thermal_alarm_n_i, .cpu_stop_exit_i, .fb_reload_i, .fb_expired_i,
    .activity_o, .stop_clock_request_n_o, .fb_load_o, .fb_load_value_o, .fb_lock_mode_o,
    .fb_tick_o, .irq_o);
  gen_in_board gen_in_board_inst (.clock_i, .pins_i(pins), .alarm_n_i(alarm_n),
    .gen_in_o(gen_in_i), .thermal_alarm_n_o(thermal_alarm_n_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int j;
    bit done;
    done = 1'b0;
    @(posedge clock_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (j = 0; j < 100 && !done; j++) begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) begin
        done = 1'b1;
        `CHK(s_axi_bresp_o, er)
      end
    end
    s_axi_bready_i <= 1'b0;
    if (!done) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int j;
    bit done;
    done = 1'b0;
    exp_rd.push_back(e);
    @(posedge clock_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (j = 0; j < 100 && !done; j++) begin
      @(posedge clock_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      done = s_axi_rvalid_o;
    end
    s_axi_rready_i <= 1'b0;
    if (!done) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge clock_i);
    {cpu_stop_exit_i, fb_reload_i, fb_expired_i} <= p;
    @(posedge clock_i);
    {cpu_stop_exit_i, fb_reload_i, fb_expired_i} <= 3'h0;
  endtask
  // Measures tick to tick, so the first tick's start-up offset does not matter.
  task automatic tick_gap();
    int j;
    for (j = 0; j < 3000 && fb_tick_o !== 1'b1; j++) @(posedge clock_i);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (fb_tick_o !== 1'b1 && n < 3000);
    if (j >= 3000 || n >= 3000) begin
      n_fail++;
      print_verdict();
    end
  endtask
  always @(posedge clock_i) begin
    if (!rst_i && s_axi_rvalid_o && s_axi_rready_i) begin
      rexp = exp_rd.pop_front();
      `CHK({s_axi_rresp_o, s_axi_rdata_o}, rexp)
    end
    if (!rst_i && fb_load_o) begin
      lexp = exp_ld.pop_front();
      `CHK({fb_lock_mode_o, fb_load_value_o}, lexp)
    end
  end
  initial begin
    seed = 5;
    n_fail = 0;
    n_checks = 0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = 4'h0;
    {s_axi_rready_i, cpu_stop_exit_i, fb_reload_i, fb_expired_i} = 4'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, pins} = 70'h0;
    s_axi_wstrb_i = 4'hF;
    alarm_n = 1'b1;
    rst_i = 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(8'h4C, 34'h0);
    rd(8'h48, 34'h0);
    rd(8'h70, {2'h2, 32'h0});
    wr(8'h70, 32'hFFFF_FFFF, 2'h2);
    wr(8'h4C, 32'hFFFF_FFFF, 2'h0);
    rd(8'h4C, {2'h0, 32'h0FFF_FFFF});
    for (i = 0; i < 10; i++) begin
      g = $random(seed) & 32'h03FF_FFFF;
      pins <= 22'($random(seed));
      wr(8'h4C, g, 2'h0);
      repeat (4) @(posedge clock_i);
      `CHK(activity_o[0], 1'b0)
      for (m = 1; m <= 13; m++) `CHK(activity_o[m], (pins[src[m]] ^ g[12 + m]) & g[m - 1])
    end
    pins <= 22'h0;
    wr(8'h4C, 32'h0C00_1C00, 2'h0);
    repeat (5) @(posedge clock_i);
    wr(8'h60, 32'h0000_3FFF, 2'h0);
    rd(8'h60, 34'h0);
    c12 = 0;
    c13 = 0;
    for (k = 0; k < 16; k++) begin
      @(posedge clock_i);
      if (k == 0) pins <= 22'h38_0000;
      if (k == 8) pins <= 22'h0;
      c12 += activity_o[12];
      c13 += activity_o[13];
    end
    `CHK(c12, 1)
    `CHK(c13, 1)
    rd(8'h60, {2'h0, 32'h0000_1C00});
    `CHK(irq_o, 1'b0)
    wr(8'h64, 32'h0000_0400, 2'h0);
    `CHK(irq_o, 1'b1)
    wr(8'h60, 32'h0000_0400, 2'h0);
    `CHK(irq_o, 1'b0)
    rd(8'h60, {2'h0, 32'h0000_1800});
    lk = 5'($random(seed));
    fc = 5'($random(seed));
    wr(8'h48, {18'h0, 3'h4, lk, 1'b1, fc}, 2'h0);
    rd(8'h48, {2'h0, 18'h0, 3'h4, lk, 1'b1, fc});
    exp_ld.push_back({1'b0, fc});
    pulse(3'h2);
    exp_ld.push_back({1'b1, lk});
    pulse(3'h4);
    tick_gap();
    `CHK(n, 800)
    pulse(3'h1);
    wr(8'h48, {18'h0, 3'h4, lk, 1'b0, fc}, 2'h0);
    exp_ld.push_back({1'b1, lk});
    pulse(3'h6);
    tick_gap();
    `CHK(n, 1000)
    pulse(3'h1);
    @(posedge clock_i);
    `CHK(fb_lock_mode_o, 1'b0)
    for (i = 1; i < 8; i++) begin
      wr(8'h48, {18'h0, i[2:0], 11'h0}, 2'h0);
      alarm_n <= 1'b0;
      repeat (8) @(posedge clock_i);
      n = 0;
      repeat (64) begin
        @(posedge clock_i);
        n += (stop_clock_request_n_o === 1'b0);
      end
      `CHK(n, 8 * i)
      alarm_n <= 1'b1;
      repeat (8) @(posedge clock_i);
    end
    rd(8'h60, {2'h0, 32'h0000_3800});
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(8'h4C, 34'h0);
    rd(8'h60, 34'h0);
    rd(8'h68, {2'h0, 32'h0000_A000});
    print_verdict();
  end
endmodule
bind gpi_monitor_burst_timer_ctl gpi_monitor_burst_timer_ctl_monitor mon_inst (.clock_i,
  .rst_i, .s_axi_bvalid_o, .gen_in_i, .thermal_alarm_n_i, .cpu_stop_exit_i, .fb_reload_i,
  .fb_expired_i, .activity_o, .stop_clock_request_n_o, .fb_load_o, .fb_lock_mode_o,
  .fb_tick_o);
